// *** hw/slot_clock.sv ***
`timescale 1ns/1ps
`include "tab_cfg.svh"
module slot_clock (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst,
    // Slot timing.
    output logic      rise,
    output logic      fall,
    output logic      low_phase
);
    localparam int HALF = `TAB_SLOT_CYC / 2;
    logic [5:0] cnt_q;
    always_ff @(posedge mclk) begin
        if (rst || cnt_q == 6'(`TAB_SLOT_CYC - 1))
            cnt_q <= 6'h00;
        else
            cnt_q <= cnt_q + 6'h01;
    end
    assign rise      = (cnt_q == 6'h00);
    assign fall      = (cnt_q == 6'(HALF));
    assign low_phase = (cnt_q >= 6'(HALF));
endmodule // slot_clock

// *** hw/tab_mem.sv ***
`timescale 1ns/1ps
module tab_mem #(
    parameter int DEPTH = 256
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Controller side.
    tab_mem_if.mem   port
);
    logic [DEPTH-1:0] stop_q;
    always_ff @(posedge mclk) begin
        if (rst)
            stop_q <= '0;
        else if (port.we)
            stop_q[port.addr] <= ~port.wdata_n;
    end
    assign port.rdata_n = ~stop_q[port.addr];
endmodule // tab_mem

// *** hw/tab_stop_ctl.sv ***
`timescale 1ns/1ps
`include "tab_cfg.svh"
module tab_stop_ctl #(
    parameter int MCLR_CYC = `TAB_MCLR_CYC
) (
    // Clock and reset.
    input  wire logic          mclk,
    input  wire logic          rst,
    // Terminal control, all from outside the clock domain.
    input  wire logic          command_arm_pulse,
    input  wire logic          char_input_strobe,
    input  wire logic [7:0]    char_code,
    input  wire logic          advance_request_n,
    input  wire logic          line_end_signal_n,
    input  wire tab_pkg::tab_addr_t x_msb,
    // Status and X register stepping.
    output logic               spacing_busy_n,
    output logic               step_pulse_n
);
    import tab_pkg::*;

    // Two-flop synchronisers; edges compare the second stage with a third flop.
    logic [4:0] s1_q, s2_q, s3_q;
    logic [7:0] c1_q, c2_q;
    tab_addr_t  x1_q, x2_q;
    always_ff @(posedge mclk) begin
        s1_q <= {command_arm_pulse, char_input_strobe, advance_request_n,
                 line_end_signal_n, 1'b0};
        s2_q <= s1_q;
        s3_q <= s2_q;
        c1_q <= char_code;
        c2_q <= c1_q;
        x1_q <= x_msb;
        x2_q <= x1_q;
    end
    wire arm_lvl   = s2_q[4];
    wire arm_fall  = s3_q[4] & ~s2_q[4];
    wire strb_rise = s2_q[3] & ~s3_q[3];
    wire adv_lo    = ~s2_q[2];
    wire adv_fall  = ~s3_q[2] & s2_q[2];
    wire adv_start = s3_q[2] & ~s2_q[2];
    wire eol_lo    = ~s2_q[1];

    logic rise, fall, low_phase;
    slot_clock u_clk (
        .mclk      (mclk),
        .rst       (rst),
        .rise      (rise),
        .fall      (fall),
        .low_phase (low_phase)
    );

    tab_mem_if mif ();
    tab_mem u_mem (
        .mclk (mclk),
        .rst  (rst),
        .port (mif.mem)
    );

    // Command flags.
    logic      arm_q, set_q, clr_q, mclr_q, search_q;
    logic [2:0] cnt_q;
    logic [31:0] mclr_cnt_q;
    tab_addr_t addr_q;
    wr_state_t st_q;
    logic      step_q;

    wire is_set  = (c2_q == `TAB_CHAR_SET);
    wire is_clr  = (c2_q == `TAB_CHAR_CLR);
    wire is_mclr = (c2_q == `TAB_CHAR_MCLR);
    wire armed_strb = arm_q & strb_rise;
    wire mclr_run   = (mclr_cnt_q != 32'h0);
    wire cmd_busy   = set_q | clr_q | mclr_run;
    wire busy       = cmd_busy | search_q;
    wire wr_ctl     = (st_q == WR_DONE);
    wire write_ok   = (st_q == WR_DONE) | (st_q == WR_MCLR);
    wire tc         = (cnt_q == 3'h7) & rise;
    wire tab_here   = ~mif.rdata_n;

    always_ff @(posedge mclk) begin
        if (rst)
            arm_q <= 1'b0;
        else if (cmd_busy)
            arm_q <= 1'b0;
        else if (arm_fall)
            arm_q <= 1'b1;
        else if (strb_rise & ~arm_lvl & ~is_set & ~is_clr & ~is_mclr)
            arm_q <= 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            set_q  <= 1'b0;
            clr_q  <= 1'b0;
            mclr_q <= 1'b0;
        end else begin
            if (st_q == WR_DONE && rise) begin
                set_q <= 1'b0;
                clr_q <= 1'b0;
            end else begin
                if (armed_strb & is_set)
                    set_q <= 1'b1;
                if (armed_strb & is_clr)
                    clr_q <= 1'b1;
            end
            if (mclr_run)
                mclr_q <= 1'b0;
            else if (armed_strb & is_mclr)
                mclr_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            mclr_cnt_q <= 32'h0;
        else if (mclr_q & ~mclr_run)
            mclr_cnt_q <= 32'(MCLR_CYC);
        else if (mclr_run)
            mclr_cnt_q <= mclr_cnt_q - 32'h1;
    end

    // Write sequence: wait for slot rise, write in low phase, release on next rise.
    always_ff @(posedge mclk) begin
        if (rst)
            st_q <= WR_IDLE;
        else begin
            case (st_q)
                WR_IDLE: if (set_q | clr_q) st_q <= WR_WAIT;
                         else if (mclr_run) st_q <= WR_MCLR;
                WR_WAIT: if (rise) st_q <= WR_DONE;
                WR_DONE: if (rise) st_q <= WR_IDLE;
                WR_MCLR: if (!mclr_run) st_q <= WR_IDLE;
                default: st_q <= WR_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            addr_q <= '0;
        else if (st_q == WR_MCLR)
            addr_q <= rise ? addr_q + 8'h01 : addr_q;
        else
            addr_q <= x2_q;
    end

    assign mif.addr    = addr_q;
    assign mif.we      = write_ok & fall;
    assign mif.wdata_n = ~set_q | (st_q == WR_MCLR);

    // Search: step, wait to count 8, check memory, repeat.
    always_ff @(posedge mclk) begin
        if (rst) begin
            search_q <= 1'b0;
            cnt_q    <= 3'h0;
        end else if (eol_lo | ~search_q & ~adv_fall) begin
            search_q <= 1'b0;
            cnt_q    <= 3'h0;
        end else if (adv_fall & ~mclr_run) begin
            search_q <= 1'b1;
            cnt_q    <= 3'h0;
        end else if (tc & tab_here) begin
            search_q <= 1'b0;
            cnt_q    <= 3'h0;
        end else if (rise)
            cnt_q <= cnt_q + 3'h1;
    end

    always_ff @(posedge mclk) begin
        if (rst)
            step_q <= 1'b0;
        else
            step_q <= ~mclr_run &
                      (adv_start |
                       (search_q & ~eol_lo & tc & ~tab_here));
    end

    assign spacing_busy_n = ~busy;
    assign step_pulse_n   = ~step_q;
    wire unused = adv_lo ^ wr_ctl ^ low_phase ^ s2_q[0] ^ s3_q[0];

    property p_disarm;
        @(posedge mclk) disable iff (rst) cmd_busy |=> !arm_q;
    endproperty
    a_disarm: assert property (p_disarm) else $error("arm kept");
    property p_nostep;
        @(posedge mclk) disable iff (rst) mclr_run |=> step_pulse_n;
    endproperty
    a_nostep: assert property (p_nostep) else $error("step in clr");

    // The checks below watch the controller's own flags and outputs.
    // They stay quiet during reset because each one is disabled while rst is high.

    sequence s_wr_end;
        st_q == WR_DONE && rise;
    endsequence
    sequence s_mark_write;
        mif.we && !mif.wdata_n;
    endsequence
    sequence s_quiet;
        st_q == WR_IDLE && !set_q && !clr_q && !mclr_q;
    endsequence

    property p_arm_set;
        @(posedge mclk) disable iff (rst)
            arm_fall && !cmd_busy |=> arm_q;
    endproperty
    a_arm_set: assert property (p_arm_set) else $error("no arm");

    property p_set_cmd;
        @(posedge mclk) disable iff (rst)
            armed_strb && is_set && !(st_q == WR_DONE && rise) |=> set_q;
    endproperty
    a_set_cmd: assert property (p_set_cmd) else $error("no set");

    property p_busy_cmd;
        @(posedge mclk) disable iff (rst)
            set_q || clr_q |-> !spacing_busy_n;
    endproperty
    a_busy_cmd: assert property (p_busy_cmd) else $error("not busy");

    property p_addr_load;
        @(posedge mclk) disable iff (rst)
            st_q != WR_MCLR |=> addr_q == $past(x2_q);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("addr");

    property p_wr_seq;
        @(posedge mclk) disable iff (rst)
            st_q == WR_WAIT && rise |=> st_q == WR_DONE;
    endproperty
    a_wr_seq: assert property (p_wr_seq) else $error("wr seq");

    property p_we_low;
        @(posedge mclk) disable iff (rst)
            mif.we |-> low_phase;
    endproperty
    a_we_low: assert property (p_we_low) else $error("we phase");

    property p_wr_clear;
        @(posedge mclk) disable iff (rst)
            s_wr_end |=> !set_q && !clr_q;
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("flags");

    // A mark written and still addressed must read back as a stop.
    property p_rd_level;
        @(posedge mclk) disable iff (rst)
            s_mark_write ##1 $stable(mif.addr) |-> tab_here;
    endproperty
    a_rd_level: assert property (p_rd_level) else $error("rd");

    property p_step_start;
        @(posedge mclk) disable iff (rst)
            adv_start && !mclr_run |=> !step_pulse_n;
    endproperty
    a_step_start: assert property (p_step_start) else $error("no step");

    // Assumes no new advance request arrives while a search is running.
    property p_step_once;
        @(posedge mclk) disable iff (rst)
            !step_pulse_n |=> step_pulse_n;
    endproperty
    a_step_once: assert property (p_step_once) else $error("step long");

    property p_search_start;
        @(posedge mclk) disable iff (rst)
            adv_fall && !eol_lo && !mclr_run |=> search_q && cnt_q == 3'h0;
    endproperty
    a_search_start: assert property (p_search_start) else $error("srch");

    property p_search_busy;
        @(posedge mclk) disable iff (rst)
            search_q |-> !spacing_busy_n;
    endproperty
    a_search_busy: assert property (p_search_busy) else $error("sbusy");

    property p_search_step;
        @(posedge mclk) disable iff (rst)
            search_q && tc && !tab_here && !eol_lo && !mclr_run
            |=> !step_pulse_n;
    endproperty
    a_search_step: assert property (p_search_step) else $error("step");

    property p_tab_stop;
        @(posedge mclk) disable iff (rst)
            search_q && tc && tab_here && !eol_lo && !adv_fall |=> !search_q;
    endproperty
    a_tab_stop: assert property (p_tab_stop) else $error("no stop");

    property p_eol;
        @(posedge mclk) disable iff (rst)
            eol_lo |=> !search_q && cnt_q == 3'h0;
    endproperty
    a_eol: assert property (p_eol) else $error("eol");

    property p_clr_cmd;
        @(posedge mclk) disable iff (rst)
            armed_strb && is_clr && !(st_q == WR_DONE && rise) |=> clr_q;
    endproperty
    a_clr_cmd: assert property (p_clr_cmd) else $error("no clear");

    property p_clr_data;
        @(posedge mclk) disable iff (rst)
            mif.we && clr_q && !set_q |-> mif.wdata_n;
    endproperty
    a_clr_data: assert property (p_clr_data) else $error("clr data");

    property p_mclr_start;
        @(posedge mclk) disable iff (rst)
            mclr_q && !mclr_run |=> mclr_run;
    endproperty
    a_mclr_start: assert property (p_mclr_start) else $error("mclr");

    property p_busy_mclr;
        @(posedge mclk) disable iff (rst)
            mclr_run |-> !spacing_busy_n;
    endproperty
    a_busy_mclr: assert property (p_busy_mclr) else $error("mbusy");

    // The sweep must step the address once per slot, wrapping at the top.
    property p_mclr_count;
        @(posedge mclk) disable iff (rst)
            st_q == WR_MCLR && rise |=> addr_q == $past(addr_q) + 8'h01;
    endproperty
    a_mclr_count: assert property (p_mclr_count) else $error("sweep");

    property p_mclr_data;
        @(posedge mclk) disable iff (rst)
            mif.we && st_q == WR_MCLR |-> mif.wdata_n;
    endproperty
    a_mclr_data: assert property (p_mclr_data) else $error("mdata");

    property p_mclr_hold;
        @(posedge mclk) disable iff (rst)
            mclr_run |=> !mclr_q;
    endproperty
    a_mclr_hold: assert property (p_mclr_hold) else $error("mflag");

    property p_unmatched;
        @(posedge mclk) disable iff (rst)
            arm_q && strb_rise && !arm_lvl && !is_set && !is_clr && !is_mclr
            && !arm_fall && !cmd_busy |=> !arm_q;
    endproperty
    a_unmatched: assert property (p_unmatched) else $error("armed");

    property p_busy_end;
        @(posedge mclk) disable iff (rst)
            s_quiet ##0 (!mclr_run && !search_q) |-> spacing_busy_n;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy");
endmodule // tab_stop_ctl

// *** shared/tab_cfg.svh ***
`ifndef TAB_CFG_SVH
`define TAB_CFG_SVH
`define TAB_CLK_MHZ        50
`define TAB_SLOT_NS        1000
`define TAB_SLOT_CYC       ((`TAB_SLOT_NS * `TAB_CLK_MHZ) / 1000)
`define TAB_MCLR_US        1500
`define TAB_MCLR_CYC       (`TAB_MCLR_US * `TAB_CLK_MHZ)
`define TAB_CHAR_SET       8'h31
`define TAB_CHAR_CLR       8'h30
`define TAB_CHAR_MCLR      8'h4d
`define TAB_SEARCH_TC      3'h0
`define TAB_ADDR_W         8
`endif

// *** shared/tab_mem_if.sv ***
`timescale 1ns/1ps
interface tab_mem_if;
    logic [7:0] addr;
    logic       we;
    logic       wdata_n;
    logic       rdata_n;
    modport ctrl (output addr, output we, output wdata_n, input rdata_n);
    modport mem  (input addr, input we, input wdata_n, output rdata_n);
endinterface

// *** shared/tab_pkg.sv ***
package tab_pkg;
    typedef enum logic [3:0] {
        WR_IDLE = 4'b0001,
        WR_WAIT = 4'b0010,
        WR_DONE = 4'b0100,
        WR_MCLR = 4'b1000
    } wr_state_t;
    typedef logic [7:0] tab_addr_t;
endpackage

// *** tb/horizontal_tab_stop_controller_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end end
module horizontal_tab_stop_controller_tb_top;
    localparam int LINE_END = 240;
    localparam int MCLR = 13000;
    logic mclk, rst, command_arm_pulse, char_input_strobe, load;
    logic advance_request_n, line_end_signal_n, spacing_busy_n, step_pulse_n;
    logic [7:0] char_code;
    logic [8:0] load_val, x_q;
    tab_pkg::tab_addr_t x_msb;
    logic tabs [256];
    logic [31:0] seed = 32'h53;
    int bad_count, n_checks, steps, t, s, e;
    tab_stop_ctl #(.MCLR_CYC(MCLR)) i_tab_stop_ctl (.mclk(mclk), .rst(rst),
        .command_arm_pulse(command_arm_pulse),
        .char_input_strobe(char_input_strobe), .char_code(char_code),
        .advance_request_n(advance_request_n),
        .line_end_signal_n(line_end_signal_n), .x_msb(x_msb),
        .spacing_busy_n(spacing_busy_n), .step_pulse_n(step_pulse_n));
    x_reg_model #(.LINE_END(LINE_END)) i_x_reg_model (.mclk(mclk),
        .rst(rst), .load(load), .load_val(load_val),
        .step_pulse_n(step_pulse_n), .x_q(x_q), .x_msb(x_msb),
        .line_end_signal_n(line_end_signal_n));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (step_pulse_n === 1'b0) steps++;
    function automatic int rnd(int n);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % n);
    endfunction
    // Steps until the new position holds a stop or reaches the line end.
    function automatic int exp_steps(int x0);
        for (int k = 1; k < 64; k++) begin
            if (tabs[((x0 + 12 * k) >> 1) & 255] || x0 + 12 * k >= LINE_END)
                return k;
        end
        return 0;
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_busy(logic lvl, int lim);
        t = 0;
        while (spacing_busy_n !== lvl && t < lim) begin
            cyc(1);
            t++;
        end
    endtask
    task automatic set_x(int v);
        cyc(1);
        load <= 1'b1;
        load_val <= 9'(v);
        cyc(1);
        load <= 1'b0;
        cyc(3);
    endtask
    task automatic command(logic [7:0] c, logic arm);
        if (arm) begin
            cyc(1);
            command_arm_pulse <= 1'b1;
            cyc(4);
            command_arm_pulse <= 1'b0;
            cyc(6);
        end
        char_code <= c;
        cyc(2);
        char_input_strobe <= 1'b1;
        cyc(4);
        char_input_strobe <= 1'b0;
    endtask
    task automatic write_cmd(int x, logic [7:0] c);
        set_x(x);
        command(c, 1'b1);
        wait_busy(1'b0, 10);
        `CHK(spacing_busy_n, 1'b0)
        wait_busy(1'b1, 300);
        `CHK(spacing_busy_n, 1'b1)
        tabs[(x >> 1) & 255] = (c == 8'h31);
    endtask
    task automatic advance(int x0);
        set_x(x0);
        e = exp_steps(x0);
        steps = 0;
        advance_request_n <= 1'b0;
        cyc(7);
        `CHK(steps, 1)
        advance_request_n <= 1'b1;
        wait_busy(1'b0, 10);
        `CHK(spacing_busy_n, 1'b0)
        wait_busy(1'b1, 60000);
        `CHK(spacing_busy_n, 1'b1)
        cyc(400);
        `CHK(steps, e)
        `CHK(x_q, 9'(x0 + 12 * e))
    endtask
    task automatic summarize();
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        summarize();
    end
    initial begin
        {command_arm_pulse, char_input_strobe, load, char_code} = '0;
        {advance_request_n, rst, load_val} = {2'b11, 9'h000};
        foreach (tabs[i]) tabs[i] = 1'b0;
        cyc(16);
        rst <= 1'b0;
        cyc(4);
        `CHK({spacing_busy_n, step_pulse_n}, 2'b11)
        write_cmd(60, 8'h31);
        advance(0);
        for (int i = 0; i < 2; i++) begin
            write_cmd(12 * (rnd(18) + 1), 8'h31);
            advance(12 * rnd(10));
        end
        do s = rnd(256); while (s == 8'h31 || s == 8'h30 || s == 8'h4d);
        command(8'(s), 1'b1);
        cyc(20);
        `CHK(spacing_busy_n, 1'b1)
        command(8'h31, 1'b0);
        cyc(20);
        `CHK(spacing_busy_n, 1'b1)
        write_cmd(60, 8'h30);
        advance(36);
        set_x(96);
        steps = 0;
        command(8'h4d, 1'b1);
        wait_busy(1'b0, 10);
        wait_busy(1'b1, MCLR + 500);
        `CHK(t >= MCLR - 20 && t <= MCLR + 100, 1'b1)
        `CHK(steps, 0)
        `CHK(x_q, 9'd96)
        foreach (tabs[i]) tabs[i] = 1'b0;
        command(8'h4d, 1'b0);
        cyc(20);
        `CHK(spacing_busy_n, 1'b1)
        advance(0);
        summarize();
    end
endmodule // horizontal_tab_stop_controller_tb_top

// *** tb/x_reg_model.sv ***
`timescale 1ns/1ps
module x_reg_model #(
    parameter int LINE_END = 240
) (
    // Clock and reset.
    input  wire logic          mclk,
    input  wire logic          rst,
    // Position load from the bench and stepping from the controller.
    input  wire logic          load,
    input  wire logic [8:0]    load_val,
    input  wire logic          step_pulse_n,
    // Position back to the controller and the bench.
    output logic [8:0]         x_q,
    output tab_pkg::tab_addr_t x_msb,
    output logic               line_end_signal_n
);
    logic [3:0] left_q;
    logic [4:0] div_q;
    // One point per 25 cycles is 2 MHz, so a step settles within 6 us.
    always_ff @(posedge mclk) begin
        div_q <= (rst || div_q == 5'd24) ? 5'd0 : div_q + 5'd1;
        if (rst || load) begin
            x_q <= rst ? 9'h000 : load_val;
            left_q <= 4'h0;
        end else if (!step_pulse_n) begin
            left_q <= left_q + 4'hc;
        end else if (left_q != 4'h0 && div_q == 5'd0) begin
            x_q <= x_q + 9'h001;
            left_q <= left_q - 4'h1;
        end
    end
    assign x_msb = x_q[8:1];
    assign line_end_signal_n = (x_q >= 9'(LINE_END)) ? 1'b0 : 1'b1;
endmodule // x_reg_model
